// ===== cdsc_pkg.sv
// Constants and types of the current driver serial control block
package cdsc_pkg;
    localparam int FRAME_W = 16;
    localparam int CRC_W = 8;
    localparam int RX_W = 24;
    localparam logic [CRC_W-1:0] CRC_POLY = 8'h07;
    localparam logic [CRC_W-1:0] CRC_INIT = 8'h00;
    localparam logic [4:0] CNT_PLAIN = 5'h10;
    localparam logic [4:0] CNT_CRC = 5'h18;
    localparam logic [4:0] CNT_HDR = 5'h04;
    localparam logic [4:0] CNT_MAX = 5'h1F;
    localparam logic [4:0] RISE_FIRST = 5'h04;
    localparam logic [4:0] RISE_LAST = 5'h14;
    localparam int ADDR_HI = 15;
    localparam int ADDR_LO = 13;
    localparam int RANGE_HI = 10;
    localparam int RANGE_LO = 7;
    localparam int CLEAR_LEVEL_SELECT_BIT = 6;
    localparam int OUTPUT_ON_BIT = 5;
    localparam int SENSE_RESISTOR_SELECT_BIT = 4;
    localparam int SWCLR_BIT = 3;
    localparam int RESET_BIT = 2;
    localparam logic [3:0] RC_4_20 = 4'h0;
    localparam logic [3:0] RC_0_24 = 4'h2;
    localparam logic [3:0] RC_4_20_OVR = 4'hD;
    localparam logic [3:0] RC_0_24_OVR = 4'hF;
    localparam logic [3:0] RANGE_RST = 4'h0;
    localparam logic OD_LOW = 1'b0;

    typedef enum logic {LK_IDLE, LK_RECV} cdsc_link_t;

    typedef struct packed {
        logic [3:0] range;
        logic clear_level_select;
        logic outOn;
        logic resSel;
        logic swClr;
    } cdsc_cfg_t;

    localparam cdsc_cfg_t CFG_RST = '{range: RANGE_RST, clear_level_select: 1'b0,
        outOn: 1'b0, resSel: 1'b1, swClr: 1'b0};

    typedef struct packed {
        logic sclk;
        logic frameSelN;
        logic sdin;
        logic [2:0] addr;
        logic hwMode;
        logic [3:0] range;
        logic sense_resistor_select;
        logic clear_level_select;
        logic clear;
        logic hot;
        logic open;
    } cdsc_pins_t;
endpackage

// ===== cdsc_crc_if.sv
// Interface between the frame logic and the CRC-8 engine
`timescale 1ns/10ps
`default_nettype none
interface cdsc_crc_if;
    logic clr;
    logic en;
    logic din;
    logic [cdsc_pkg::CRC_W-1:0] crc;
    modport eng (input clr, input en, input din, output crc);
    modport user (output clr, output en, output din, input crc);
endinterface
`default_nettype wire

// ===== cdsc_crc8.sv
// Serial CRC-8 engine, one bit per enable
`timescale 1ns/10ps
`default_nettype none
module cdsc_crc8 (
    input wire logic core_clk,
    input wire logic rst_b,
    cdsc_crc_if.eng crcBus
);
    import cdsc_pkg::*;

    logic [CRC_W-1:0] crc_ff;
    logic [CRC_W-1:0] nxt_crc_ff;
    logic fb;

    always_comb begin
        fb = crc_ff[CRC_W-1] ^ crcBus.din;
        nxt_crc_ff = crc_ff;
        if (crcBus.clr) begin
            nxt_crc_ff = CRC_INIT;
        end else if (crcBus.en) begin
            nxt_crc_ff = {crc_ff[CRC_W-2:0], 1'b0} ^ (fb ? CRC_POLY : CRC_INIT);
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            crc_ff <= CRC_INIT;
        end else begin
            crc_ff <= nxt_crc_ff;
        end
    end

    assign crcBus.crc = crc_ff;
endmodule
`default_nettype wire

// ===== cdsc_top.sv
// Serial control, readback and fault logic of the current driver
`timescale 1ns/10ps
`default_nettype none
module cdsc_top (
    input wire logic core_clk,
    input wire logic rst_b,
    input wire logic sclkPin,
    input wire logic frameSelPinN,
    input wire logic sdinPin,
    output logic serialOut,
    output logic serialOutOeN,
    input wire logic [2:0] deviceAddrPins,
    input wire logic hwModePin,
    input wire logic [3:0] rangeCodePins,
    input wire logic senseResistorPin,
    input wire logic clearSelPin,
    input wire logic clearPin,
    input wire logic overheatDet,
    input wire logic openOutputDet,
    output logic faultOut,
    output logic faultOeN,
    output logic openOutputFaultN,
    output logic openOutputFaultOeN,
    output logic currentOutputOn,
    output logic clearActive,
    output logic clearToMid,
    output logic [3:0] rangeCode,
    output logic internalResistor,
    output logic rangeValid,
    output logic [cdsc_pkg::FRAME_W-1:0] statusReadbackWord
);
    import cdsc_pkg::*;

    default clocking defClk @(posedge core_clk);
    endclocking
    default disable iff (!rst_b);

    cdsc_crc_if crcBus ();

    cdsc_crc8 u_crc (
        .core_clk(core_clk),
        .rst_b(rst_b),
        .crcBus(crcBus.eng)
    );

    // Input synchronisers
    // Select resets to its idle level, so reset makes no false frame start
    localparam cdsc_pins_t PINS_IDLE = '{sclk: 1'b0, frameSelN: 1'b1,
        sdin: 1'b0, addr: 3'h0, hwMode: 1'b0, range: 4'h0, sense_resistor_select: 1'b0,
        clear_level_select: 1'b0, clear: 1'b0, hot: 1'b0, open: 1'b0};
    cdsc_pins_t pinsIn;
    cdsc_pins_t syncA_ff;
    cdsc_pins_t syncB_ff;
    cdsc_pins_t nxt_syncA_ff;
    cdsc_pins_t nxt_syncB_ff;
    logic sclkC_ff;
    logic selC_ff;
    logic nxt_sclkC_ff;
    logic nxt_selC_ff;

    assign pinsIn = '{sclk: sclkPin, frameSelN: frameSelPinN,
        sdin: sdinPin, addr: deviceAddrPins, hwMode: hwModePin,
        range: rangeCodePins, sense_resistor_select: senseResistorPin,
        clear_level_select: clearSelPin, clear: clearPin, hot: overheatDet,
        open: openOutputDet};

    always_comb begin
        nxt_syncA_ff = pinsIn;
        nxt_syncB_ff = syncA_ff;
        nxt_sclkC_ff = syncB_ff.sclk;
        nxt_selC_ff = syncB_ff.frameSelN;
    end

    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            syncA_ff <= PINS_IDLE;
            syncB_ff <= PINS_IDLE;
            sclkC_ff <= 1'b0;
            selC_ff <= 1'b1;
        end else begin
            syncA_ff <= nxt_syncA_ff;
            syncB_ff <= nxt_syncB_ff;
            sclkC_ff <= nxt_sclkC_ff;
            selC_ff <= nxt_selC_ff;
        end
    end

    logic sclkRise;
    logic sclkFall;
    logic selFall;
    logic selRise;
    logic hwS;
    logic hotS;
    logic openS;

    assign sclkRise = syncB_ff.sclk & ~sclkC_ff;
    assign sclkFall = ~syncB_ff.sclk & sclkC_ff;
    assign selFall = ~syncB_ff.frameSelN & selC_ff;
    assign selRise = syncB_ff.frameSelN & ~selC_ff;
    assign hwS = syncB_ff.hwMode;
    assign hotS = syncB_ff.hot;
    assign openS = syncB_ff.open;

    // Link state
    cdsc_link_t link_ff;
    cdsc_link_t nxt_link_ff;
    logic [4:0] bitCnt_ff;
    logic [4:0] nxt_bitCnt_ff;
    logic [4:0] riseCnt_ff;
    logic [4:0] nxt_riseCnt_ff;
    logic [RX_W-1:0] rx_ff;
    logic [RX_W-1:0] nxt_rx_ff;
    logic [FRAME_W-1:0] tx_ff;
    logic [FRAME_W-1:0] nxt_tx_ff;
    logic readReq_ff;
    logic nxt_readReq_ff;
    logic sdo_ff;
    logic nxt_sdo_ff;
    logic sdoOeN_ff;
    logic nxt_sdoOeN_ff;
    logic [3:0] header;
    logic frameDone;

    cdsc_cfg_t cfg_ff;
    cdsc_cfg_t nxt_cfg_ff;
    logic pecFlag_ff;
    logic nxt_pecFlag_ff;
    logic [FRAME_W-1:0] readback;

    // Status and control share one word
    assign readback = {syncB_ff.addr, 1'b1, 1'b0, cfg_ff.range,
        cfg_ff.clear_level_select, cfg_ff.outOn, cfg_ff.resSel,
        pecFlag_ff, hotS, openS, 1'b0};

    assign frameDone = (link_ff == LK_RECV) && selRise;

    always_comb begin
        nxt_link_ff = link_ff;
        nxt_bitCnt_ff = bitCnt_ff;
        nxt_riseCnt_ff = riseCnt_ff;
        nxt_rx_ff = rx_ff;
        nxt_tx_ff = tx_ff;
        nxt_readReq_ff = readReq_ff;
        nxt_sdo_ff = sdo_ff;
        nxt_sdoOeN_ff = sdoOeN_ff;
        header = {rx_ff[2:0], syncB_ff.sdin};
        crcBus.clr = 1'b0;
        crcBus.en = 1'b0;
        crcBus.din = syncB_ff.sdin;
        case (link_ff)
            LK_IDLE: begin
                if (selFall) begin
                    nxt_link_ff = LK_RECV;
                    nxt_bitCnt_ff = '0;
                    nxt_riseCnt_ff = '0;
                    nxt_readReq_ff = 1'b0;
                    crcBus.clr = 1'b1;
                end
            end
            LK_RECV: begin
                if (sclkFall && bitCnt_ff != CNT_MAX) begin
                    nxt_rx_ff = {rx_ff[RX_W-2:0], syncB_ff.sdin};
                    nxt_bitCnt_ff = bitCnt_ff + 5'h01;
                    crcBus.en = 1'b1;
                    // Address match and read flag
                    if (bitCnt_ff == CNT_HDR - 5'h01 &&
                        header[3:1] == syncB_ff.addr && header[0]) begin
                        nxt_readReq_ff = 1'b1;
                        nxt_tx_ff = readback;
                    end
                end
                if (sclkRise && riseCnt_ff != CNT_MAX) begin
                    nxt_riseCnt_ff = riseCnt_ff + 5'h01;
                    // MSB first from the 5th rising edge
                    if (readReq_ff && riseCnt_ff >= RISE_FIRST &&
                        riseCnt_ff < RISE_LAST) begin
                        nxt_sdo_ff = tx_ff[FRAME_W-1];
                        nxt_tx_ff = {tx_ff[FRAME_W-2:0], 1'b0};
                        nxt_sdoOeN_ff = 1'b0;
                    end
                end
                if (selRise) begin
                    nxt_link_ff = LK_IDLE;
                    nxt_sdoOeN_ff = 1'b1;
                end
            end
            default: begin
                nxt_link_ff = LK_IDLE;
                nxt_sdoOeN_ff = 1'b1;
            end
        endcase
    end

    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            link_ff <= LK_IDLE;
            bitCnt_ff <= '0;
            riseCnt_ff <= '0;
            rx_ff <= '0;
            tx_ff <= '0;
            readReq_ff <= 1'b0;
            sdo_ff <= 1'b0;
            sdoOeN_ff <= 1'b1;
        end else begin
            link_ff <= nxt_link_ff;
            bitCnt_ff <= nxt_bitCnt_ff;
            riseCnt_ff <= nxt_riseCnt_ff;
            rx_ff <= nxt_rx_ff;
            tx_ff <= nxt_tx_ff;
            readReq_ff <= nxt_readReq_ff;
            sdo_ff <= nxt_sdo_ff;
            sdoOeN_ff <= nxt_sdoOeN_ff;
        end
    end

    // Frame check and configuration update
    logic [FRAME_W-1:0] frameWord;
    logic crcBad;
    logic lenOk;
    logic addrHit;
    logic doWrite;

    always_comb begin
        frameWord = (bitCnt_ff == CNT_CRC) ? rx_ff[RX_W-1:CRC_W] :
            rx_ff[FRAME_W-1:0];
        crcBad = (bitCnt_ff == CNT_CRC) && (crcBus.crc != CRC_INIT);
        lenOk = (bitCnt_ff == CNT_PLAIN) ||
            ((bitCnt_ff == CNT_CRC) && !crcBad);
        addrHit = frameWord[ADDR_HI:ADDR_LO] == syncB_ff.addr;
        doWrite = frameDone && lenOk && addrHit && !hwS;
        nxt_cfg_ff = cfg_ff;
        if (doWrite) begin
            if (frameWord[RESET_BIT]) begin
                nxt_cfg_ff = CFG_RST;
            end else begin
                nxt_cfg_ff.range = frameWord[RANGE_HI:RANGE_LO];
                nxt_cfg_ff.clear_level_select = frameWord[CLEAR_LEVEL_SELECT_BIT];
                nxt_cfg_ff.outOn = frameWord[OUTPUT_ON_BIT];
                nxt_cfg_ff.resSel = frameWord[SENSE_RESISTOR_SELECT_BIT];
                nxt_cfg_ff.swClr = frameWord[SWCLR_BIT];
            end
        end
        nxt_pecFlag_ff = pecFlag_ff;
        if (frameDone && readReq_ff) begin
            nxt_pecFlag_ff = 1'b0;
        end
        // A new failure wins over the read clear
        if (frameDone && crcBad && !hwS) begin
            nxt_pecFlag_ff = 1'b1;
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            cfg_ff <= CFG_RST;
            pecFlag_ff <= 1'b0;
        end else begin
            cfg_ff <= nxt_cfg_ff;
            pecFlag_ff <= nxt_pecFlag_ff;
        end
    end

    // Outputs toward the analog stage and the fault pins
    logic nxt_outOn;
    logic nxt_clrAct;
    logic nxt_clrMid;
    logic [3:0] nxt_range;
    logic nxt_intRes;
    logic nxt_valid;
    logic nxt_faultOeN;
    logic nxt_openOeN;

    always_comb begin
        nxt_range = hwS ? syncB_ff.range : cfg_ff.range;
        nxt_intRes = hwS ? syncB_ff.sense_resistor_select : cfg_ff.resSel;
        nxt_outOn = hwS | cfg_ff.outOn;
        nxt_clrAct = syncB_ff.clear | (~hwS & cfg_ff.swClr);
        nxt_clrMid = syncB_ff.clear_level_select | (~hwS & cfg_ff.clear_level_select);
        case (nxt_range)
            RC_4_20, RC_0_24, RC_4_20_OVR, RC_0_24_OVR: begin
                nxt_valid = 1'b1;
            end
            default: begin
                nxt_valid = 1'b0;
            end
        endcase
        // Shared pin: any flag in software, overheat in hardware
        nxt_faultOeN = hwS ? ~hotS :
            ~(pecFlag_ff | hotS | openS);
        nxt_openOeN = hwS ? ~openS : 1'b1;
    end

    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            currentOutputOn <= 1'b0;
            clearActive <= 1'b0;
            clearToMid <= 1'b0;
            rangeCode <= RANGE_RST;
            internalResistor <= CFG_RST.resSel;
            rangeValid <= 1'b1;
            faultOeN <= 1'b1;
            openOutputFaultOeN <= 1'b1;
            statusReadbackWord <= '0;
        end else begin
            currentOutputOn <= nxt_outOn;
            clearActive <= nxt_clrAct;
            clearToMid <= nxt_clrMid;
            rangeCode <= nxt_range;
            internalResistor <= nxt_intRes;
            rangeValid <= nxt_valid;
            faultOeN <= nxt_faultOeN;
            openOutputFaultOeN <= nxt_openOeN;
            statusReadbackWord <= readback;
        end
    end

    assign faultOut = OD_LOW;
    assign openOutputFaultN = OD_LOW;
    assign serialOut = sdo_ff;
    assign serialOutOeN = sdoOeN_ff;

    AST_CLR_MID: assert property (
        !hwS && cfg_ff.clear_level_select |=> clearToMid)
        else $error("clear select bit ignored");
    AST_OUT_OFF: assert property (
        !hwS && !cfg_ff.outOn |=> !currentOutputOn)
        else $error("output on without enable bit");
    AST_SW_CLR: assert property (
        !hwS && cfg_ff.swClr |=> clearActive)
        else $error("software clear not applied");
    AST_RES_SEL: assert property (
        !hwS |=> internalResistor == $past(cfg_ff.resSel))
        else $error("resistor select mismatch");
    AST_SW_RESET: assert property (
        doWrite && frameWord[RESET_BIT] |=> cfg_ff == CFG_RST)
        else $error("reset bit did not restore defaults");
    AST_SDO_IDLE: assert property (
        !readReq_ff |-> serialOutOeN)
        else $error("serial out driven without read");
    AST_SDO_OFF: assert property (
        frameDone |=> serialOutOeN [*2])
        else $error("serial out not released at frame end");
    AST_FAULT: assert property (
        !hwS && (pecFlag_ff || hotS || openS) |=> !faultOeN)
        else $error("fault pin not pulled low");
    AST_HW_RANGE: assert property (
        hwS |=> rangeCode == $past(syncB_ff.range))
        else $error("hardware range pins ignored");
    AST_HW_OPEN: assert property (
        hwS && openS |=> !openOutputFaultOeN)
        else $error("open output pin not pulled low");
    AST_HW_HOT: assert property (
        hwS && hotS |=> !faultOeN)
        else $error("overheat pin not pulled low");
    AST_PEC_SET: assert property (
        frameDone && crcBad && !hwS |=> pecFlag_ff && $stable(cfg_ff))
        else $error("bad check not flagged or written");
    AST_PEC_CLR: assert property (
        frameDone && readReq_ff && !crcBad |=> !pecFlag_ff)
        else $error("status read did not clear check flag");
    AST_NO_HIT: assert property (
        frameDone && !addrHit |=> $stable(cfg_ff))
        else $error("foreign frame changed settings");
endmodule
`default_nettype wire

// ===== cdsc_host_model.sv
// Host serial master model that drives frames and gathers readback
`timescale 1ns/10ps
`default_nettype none
module cdsc_host_model (
    input wire logic core_clk,
    output var logic sclk,
    output var logic frameSelN,
    output var logic sdin,
    input wire logic serialOut,
    input wire logic serialOutOeN
);
    initial begin
        sclk = 1'b0;
        frameSelN = 1'b1;
        sdin = 1'b0;
    end

    // Half a serial clock period, stretched by slow
    task automatic half(input int slow);
        repeat (4 * slow) @(posedge core_clk);
        #1;
    endtask

    // Sends n bits MSB first from bit 23, samples readback before rises
    task automatic frame(input logic [23:0] bits, input int n,
            input int slow, output logic [15:0] rd, output logic oeSeen);
        rd = 16'h0000;
        oeSeen = 1'b1;
        half(1);
        frameSelN = 1'b0;
        for (int k = 1; k <= n; k++) begin
            half(slow);
            if (k >= 6 && k <= 21) begin
                // Released line reads inverted, as nothing holds it
                rd[21-k] = serialOutOeN ? ~serialOut : serialOut;
                oeSeen = oeSeen & ~serialOutOeN;
            end
            sdin = bits[24-k];
            sclk = 1'b1;
            half(slow);
            sclk = 1'b0;
        end
        half(slow);
        frameSelN = 1'b1;
        // Released data line must not keep the last value
        sdin = ~sdin;
        half(1);
    endtask
endmodule
`default_nettype wire

// ===== cdsc_top_tb_top.sv
// Self-checking testbench of the current driver serial control block
`timescale 1ns/10ps
`default_nettype none
module cdsc_top_tb_top;
    import cdsc_pkg::*;
    localparam logic [2:0] DEV = 3'h5;
    logic core_clk, rst_b, sclk, selN, sdin, sOut, sOutOeN;
    logic hwMode, clrSelPin, clrPin, hot, openDet, resPin;
    logic [3:0] rangePins, rangeCode;
    logic faultOut, faultOeN, openFaultN, openFaultOeN;
    logic outOn, clrAct, clrMid, intRes, rangeValid, oeSeen;
    logic [15:0] rbWord, rd;
    int badCount, samplesChecked, cycles;

    cdsc_top uut (.core_clk(core_clk), .rst_b(rst_b), .sclkPin(sclk),
        .frameSelPinN(selN), .sdinPin(sdin), .serialOut(sOut),
        .serialOutOeN(sOutOeN), .deviceAddrPins(DEV), .hwModePin(hwMode),
        .rangeCodePins(rangePins), .senseResistorPin(resPin),
        .clearSelPin(clrSelPin), .clearPin(clrPin), .overheatDet(hot),
        .openOutputDet(openDet), .faultOut(faultOut), .faultOeN(faultOeN),
        .openOutputFaultN(openFaultN), .openOutputFaultOeN(openFaultOeN),
        .currentOutputOn(outOn), .clearActive(clrAct),
        .clearToMid(clrMid), .rangeCode(rangeCode),
        .internalResistor(intRes), .rangeValid(rangeValid),
        .statusReadbackWord(rbWord));

    cdsc_host_model host (.core_clk(core_clk), .sclk(sclk),
        .frameSelN(selN), .sdin(sdin), .serialOut(sOut),
        .serialOutOeN(sOutOeN));

    initial core_clk = 1'b0;
    always #25 core_clk = ~core_clk;

    task automatic printVerdict();
        if (badCount == 0 && samplesChecked > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    always @(posedge core_clk) begin
        cycles++;
        if (cycles == 20000) begin
            badCount++;
            $display("mismatch at %0t: run did not finish", $time);
            printVerdict();
        end
    end

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        samplesChecked++;
        if (seen !== exp) begin
            badCount++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen,
                exp);
        end
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge core_clk);
        #1;
    endtask

    function automatic logic [7:0] crc8(input logic [15:0] d);
        logic [7:0] c;
        c = CRC_INIT;
        for (int i = 15; i >= 0; i--)
            c = {c[6:0], 1'b0} ^ ((c[7] ^ d[i]) ? CRC_POLY : 8'h00);
        return c;
    endfunction

    function automatic logic [15:0] cmd(input logic [2:0] a,
            input logic rdf, input logic [3:0] rg, input logic cs,
            input logic on, input logic rs, input logic sc, input logic rst);
        return {a, rdf, 1'b0, rg, cs, on, rs, sc, rst, 2'b00};
    endfunction

    function automatic logic [15:0] rbExp(input logic [3:0] rg,
            input logic cs, input logic on, input logic rs,
            input logic [2:0] flags);
        return {DEV, 1'b1, 1'b0, rg, cs, on, rs, flags, 1'b0};
    endfunction

    // Plain frames carry 16 bits, checked frames append the CRC
    task automatic xfer(input logic [15:0] w, input int n,
            input logic [7:0] flip, input int slow);
        host.frame({w, crc8(w) ^ flip}, n, slow, rd, oeSeen);
        tick(8);
    endtask

    task automatic cfgIs(input logic [3:0] rg, input logic cs,
            input logic on, input logic rs);
        check(16'({rangeCode, clrMid, outOn, intRes}), 16'({rg, cs, on, rs}));
    endtask

    initial begin
        rst_b = 1'b0;
        hwMode = 1'b0;
        clrSelPin = 1'b0;
        clrPin = 1'b0;
        hot = 1'b0;
        openDet = 1'b0;
        resPin = 1'b1;
        rangePins = 4'h0;
        tick(16);
        rst_b = 1'b1;
        tick(6);
        cfgIs(RANGE_RST, 1'b0, 1'b0, 1'b1);
        check(16'({sOutOeN, faultOeN, rangeValid}), 16'h7);

        xfer(cmd(DEV, 0, RC_0_24, 1, 1, 0, 0, 0), 16, 8'h00, 1);
        cfgIs(RC_0_24, 1'b1, 1'b1, 1'b0);
        check(16'({oeSeen, rangeValid}), 16'h1);
        xfer(cmd(DEV, 0, RC_0_24, 1, 1, 0, 1, 0), 16, 8'h00, 1);
        check(16'(clrAct), 16'h1);
        xfer(cmd(DEV, 0, RC_0_24, 1, 1, 0, 0, 0), 16, 8'h00, 1);
        check(16'(clrAct), 16'h0);
        clrPin = 1'b1;
        tick(6);
        check(16'(clrAct), 16'h1);
        clrPin = 1'b0;

        xfer(cmd(DEV ^ 3'h1, 0, RC_4_20, 0, 0, 1, 0, 0), 16, 8'h00,
            1);
        cfgIs(RC_0_24, 1'b1, 1'b1, 1'b0);

        // Read frame also writes new control bits
        xfer(cmd(DEV, 1, RC_4_20, 0, 1, 1, 0, 0), 24, 8'h00, 1);
        check(rd, rbExp(RC_0_24, 1, 1, 0, 3'h0));
        check(16'({oeSeen, sOutOeN}), 16'h3);
        cfgIs(RC_4_20, 1'b0, 1'b1, 1'b1);
        check(rbWord, rbExp(RC_4_20, 0, 1, 1, 3'h0));

        hot = 1'b1;
        openDet = 1'b1;
        tick(6);
        check(16'(faultOeN), 16'h0);
        xfer(cmd(DEV, 1, RC_4_20, 0, 1, 1, 0, 0), 24, 8'h00, 1);
        check(rd, rbExp(RC_4_20, 0, 1, 1, 3'h3));
        check(rbWord, rbExp(RC_4_20, 0, 1, 1, 3'h3));
        hot = 1'b0;
        openDet = 1'b0;
        tick(6);
        check(16'(faultOeN), 16'h1);

        xfer(cmd(DEV, 0, RC_0_24, 1, 0, 0, 0, 0), 24, 8'h01, 1);
        cfgIs(RC_4_20, 1'b0, 1'b1, 1'b1);
        check(16'(faultOeN), 16'h0);
        xfer(cmd(DEV, 1, RC_4_20, 0, 1, 1, 0, 0), 24, 8'h00, 1);
        check(rd, rbExp(RC_4_20, 0, 1, 1, 3'h4));
        check(16'(faultOeN), 16'h1);
        xfer(cmd(DEV, 1, RC_4_20, 0, 1, 1, 0, 0), 24, 8'h00, 1);
        check(rd, rbExp(RC_4_20, 0, 1, 1, 3'h0));

        xfer(cmd(DEV, 0, RC_0_24, 1, 1, 0, 0, 1), 16, 8'h00, 1);
        cfgIs(RANGE_RST, 1'b0, 1'b0, 1'b1);

        hwMode = 1'b1;
        resPin = 1'b0;
        for (int c = 0; c < 16; c++) begin
            rangePins = 4'(c);
            tick(6);
            check(16'({rangeCode, intRes}), 16'({4'(c), 1'b0}));
            check(16'(rangeValid), 16'(c == 0 || c == 2 || c == 13 ||
                c == 15));
        end
        openDet = 1'b1;
        tick(6);
        check(16'({openFaultOeN, faultOeN}), 16'h1);
        hot = 1'b1;
        tick(6);
        check(16'({openFaultOeN, faultOeN}), 16'h0);
        check(16'({openFaultN, faultOut}), 16'h0);
        printVerdict();
    end
endmodule
`default_nettype wire
